// [ppg_regs.svh]
// Register offsets, field positions, reset values and timing counts for the pitch governor.
// Assumes a 10 MHz system clock and an AXI4-Lite register bus with 32-bit data.
`ifndef PPG_REGS_SVH
`define PPG_REGS_SVH
// ======================================================================
// Register byte offsets
`define PPG_CTRL_OFS 8'h00
`define PPG_TARGET_OFS 8'h04
`define PPG_GEAR_OFS 8'h08
`define PPG_MAXRPM_OFS 8'h0c
`define PPG_STATUS_OFS 8'h10
`define PPG_SPEED_OFS 8'h14
// ======================================================================
// Control field positions
`define PPG_CTRL_HOLD 0
`define PPG_CTRL_SPDEN 1
`define PPG_CTRL_CALSHOW 2
// ======================================================================
// Reset values, maximum-speed write limit and lock window width
`define PPG_TARGET_RST 12'd2500
`define PPG_MAXRPM_RST 12'd2700
`define PPG_MAXRPM_LIMIT 12'd2900
`define PPG_GEAR_RST 16'h0100
`define PPG_WINDOW_RPM 12'd10
// ======================================================================
// Timing: one tick every 1 ms, selection timeout 3 s, resume delay 1 s, pulse timeout 2 s
`define PPG_CLK_HZ 10000000
`define PPG_TICK_US 1000
`define PPG_TICK_CYC ((`PPG_CLK_HZ / 1000000) * `PPG_TICK_US)
`define PPG_SEL_MS 3000
`define PPG_RESUME_MS 1000
`define PPG_NOPULSE_MS 2000
`endif

// [ppg_pkg.sv]
// Types shared by the pitch governor.
// Assumes ppg_regs.svh supplies the numeric constants.
package ppg_pkg;
  typedef enum logic [1:0] {
    PPG_IDLE = 2'b00,
    PPG_FINE = 2'b01,
    PPG_COARSE = 2'b10
  } ppg_drive_t;
  typedef struct packed {
    logic hold;
    logic speedEnable;
    logic calShow;
  } ppg_ctrl_t;
  typedef struct packed {
    logic motorA;
    logic motorB;
  } ppg_servo_t;
  typedef struct packed {
    logic stateGreen;
    logic stateRed;
    logic selectionColon;
    logic targetLock;
    logic [3:0] dots;
    logic [15:0] digits;
  } ppg_panel_t;
endpackage

// [ppg_governor.sv]
// Constant-speed propeller pitch governor with AXI4-Lite registers.
// Assumes the knob, stop and injector inputs are asynchronous pins.
`include "ppg_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module ppg_governor #(
  parameter int TICK_CYC = `PPG_TICK_CYC
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // AXI4-Lite write channels.
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read channels.
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Pilot knob: busy level and the new value it produced.
  input wire logic knobBusy,
  input wire logic [11:0] knobRpm,
  // Engine and hub inputs.
  input wire logic injectorPulse,
  input wire logic fineStop,
  input wire logic coarseStop,
  // Servo motor and panel.
  output ppg_pkg::ppg_servo_t servo,
  output ppg_pkg::ppg_panel_t panel
);
  // ======================================================================
  // State
  typedef struct packed {
    logic [2:0] syncKnob0;
    // Knob value passes the same two stages as its busy line, so both land together.
    logic [11:0] syncRpm0;
    logic [11:0] syncRpm1;
    logic [2:0] syncKnob1;
    logic [1:0] syncMisc0;
    logic [1:0] syncMisc1;
    logic injPrev;
    logic [15:0] tickCnt;
    logic [15:0] msSinceInj;
    logic [15:0] periodMs;
    logic pulseSeen;
    ppg_pkg::ppg_ctrl_t ctrl;
    logic [11:0] target;
    logic [15:0] gear;
    logic [11:0] maxRpm;
    logic [11:0] propRpm;
    logic [15:0] selMs;
    logic [15:0] resumeMs;
    logic holdFrozen;
    logic powerUp;
    ppg_pkg::ppg_drive_t drive;
    logic awHeld;
    logic [7:0] awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bv;
    logic rv;
    logic [31:0] rd;
    logic [1:0] rr;
    logic [1:0] br;
    ppg_pkg::ppg_servo_t servo;
    ppg_pkg::ppg_panel_t panel;
  } ppg_state_t;

  ppg_state_t s;
  ppg_state_t next_s;

  // Engine speed from pulse period in ms: rpm = 2 * 60000 / period.
  function automatic logic [11:0] ppg_rpm(input logic [15:0] periodMs, input logic [15:0] gear);
    logic [31:0] engine;
    // The product is kept at 48 bits: a full-scale gear word times the fastest
    // engine speed does not fit in 32 bits and would wrap to a small, wrong speed.
    logic [47:0] prop;
    engine = 32'd0;
    prop = 48'd0;
    if (periodMs != 16'h0000) begin
      engine = 32'd120000 / {16'h0000, periodMs};
    end
    prop = (engine * {16'h0000, gear}) >> 8;
    if (prop > 48'd4095) begin
      prop = 32'd4095;
    end
    return prop[11:0];
  endfunction

  // Binary value rounded to tens and split into four BCD digits.
  function automatic logic [15:0] ppg_bcd(input logic [11:0] v);
    logic [13:0] r;
    logic [3:0] d3;
    logic [3:0] d2;
    logic [3:0] d1;
    r = (({2'b00, v} + 14'd5) / 14'd10) * 14'd10;
    if (r > 14'd9990) begin
      r = 14'd9990;
    end
    d3 = 4'((r / 14'd1000) % 14'd10);
    d2 = 4'((r / 14'd100) % 14'd10);
    d1 = 4'((r / 14'd10) % 14'd10);
    return {d3, d2, d1, 4'h0};
  endfunction

  logic tick;
  logic knobNow;
  logic injNow;
  logic fineNow;
  logic coarseNow;
  logic [11:0] knobVal;
  logic locked;
  logic suspended;
  logic doWrite;
  logic [31:0] wv;
  logic [31:0] merged;
  logic [31:0] cur;
  logic [12:0] spdHi;
  logic [12:0] tgtHi;

  // Stable versions of the pin inputs after two flip-flops.
  assign knobNow = s.syncKnob1[0];
  assign injNow = s.syncKnob1[1];
  assign fineNow = s.syncMisc1[0];
  assign coarseNow = s.syncMisc1[1];
  assign knobVal = s.syncRpm1;
  // The divider gives a one-cycle tick every millisecond; all slow timers count
  // ticks, so TICK_CYC alone scales them for a short simulation.
  assign tick = (s.tickCnt == 16'(TICK_CYC - 1));

  // ======================================================================
  // Next-state logic
  always_comb begin
    next_s = s;
    wv = 32'h0;
    merged = 32'h0;
    cur = 32'h0;
    doWrite = 1'b0;
    // Synchronisers; the first stage feeds only the second.
    next_s.syncKnob0 = {1'b0, injectorPulse, knobBusy};
    next_s.syncKnob1 = s.syncKnob0;
    next_s.syncMisc0 = {coarseStop, fineStop};
    next_s.syncMisc1 = s.syncMisc0;
    next_s.syncRpm0 = knobRpm;
    next_s.syncRpm1 = s.syncRpm0;
    next_s.injPrev = injNow;
    next_s.tickCnt = tick ? 16'h0000 : s.tickCnt + 16'h0001;
    // Pulse interval timed in 1 ms ticks; each pulse is two engine turns.
    // A tick that lands on the pulse edge still belongs to the period that is
    // ending; dropping it would read one millisecond short at some phases.
    if (injNow && !s.injPrev) begin
      next_s.periodMs = s.msSinceInj + 16'(tick);
      next_s.msSinceInj = 16'h0000;
      next_s.pulseSeen = 1'b1;
    end else if (tick) begin
      if (s.msSinceInj != 16'hffff) begin
        next_s.msSinceInj = s.msSinceInj + 16'h0001;
      end
      if (s.msSinceInj >= 16'(`PPG_NOPULSE_MS)) begin
        next_s.pulseSeen = 1'b0;
      end
    end
    // Speed is worked out every cycle from the last period, so a gear word written
    // over the bus shows at once instead of waiting for the next pulse.
    // Propeller speed, corrected for the reduction gearbox.
    next_s.propRpm = s.pulseSeen ? ppg_rpm(s.periodMs, s.gear) : 12'd0;
    // Knob activity: suspend and reload selection and resume timers.
    if (knobNow) begin
      next_s.target = (knobVal > s.maxRpm) ? s.maxRpm : knobVal;
      next_s.selMs = 16'(`PPG_SEL_MS);
      next_s.resumeMs = 16'(`PPG_RESUME_MS);
      next_s.holdFrozen = 1'b0;
    end else if (tick) begin
      if (s.selMs != 16'h0000) begin
        next_s.selMs = s.selMs - 16'h0001;
      end
      if (s.resumeMs != 16'h0000) begin
        next_s.resumeMs = s.resumeMs - 16'h0001;
      end
    end
    // The power-up seek ends only when the fine stop is met.
    if (fineNow) begin
      next_s.powerUp = 1'b0;
    end
    // Window edges are formed one bit wider so that a speed near full scale
    // cannot wrap around and look slow.
    spdHi = {1'b0, s.propRpm} + {1'b0, `PPG_WINDOW_RPM};
    tgtHi = {1'b0, s.target} + {1'b0, `PPG_WINDOW_RPM};
    locked = s.pulseSeen && (spdHi >= {1'b0, s.target}) &&
             ({1'b0, s.propRpm} <= tgtHi);
    // Hold mode: the first lock freezes pitch. A new target or leaving hold mode
    // releases it; the lock is judged against the target already in force, so a
    // set in the same cycle as a knob clear wins and is a lock on the old value.
    if (s.ctrl.hold && locked && !s.powerUp) begin
      next_s.holdFrozen = 1'b1;
    end
    if (!s.ctrl.hold) begin
      next_s.holdFrozen = 1'b0;
    end
    // Once the power-up seek has ended, pitch moves only outside the lock window; inside it the motor rests, which
    // keeps the servo from hunting to and fro around the target.
    // Drive choice: power-up seek, else governed by speed error.
    next_s.drive = ppg_pkg::PPG_IDLE;
    if (s.powerUp) begin
      next_s.drive = ppg_pkg::PPG_FINE;
    end else if (knobNow || s.resumeMs != 16'h0000 || s.holdFrozen || !s.pulseSeen) begin
      next_s.drive = ppg_pkg::PPG_IDLE;
    end else if ({1'b0, s.propRpm} > tgtHi) begin
      next_s.drive = ppg_pkg::PPG_COARSE;
    end else if (spdHi < {1'b0, s.target}) begin
      next_s.drive = ppg_pkg::PPG_FINE;
    end
    // The stop inputs act last, so no branch above can push the blades further
    // into a stop that is already met.
    // A reached stop blocks motion further into that stop.
    if ((next_s.drive == ppg_pkg::PPG_FINE && fineNow) ||
        (next_s.drive == ppg_pkg::PPG_COARSE && coarseNow)) begin
      next_s.drive = ppg_pkg::PPG_IDLE;
    end
    next_s.servo.motorA = (next_s.drive == ppg_pkg::PPG_FINE);
    next_s.servo.motorB = (next_s.drive == ppg_pkg::PPG_COARSE);
    suspended = (next_s.drive == ppg_pkg::PPG_IDLE) && !locked;
    next_s.panel.stateGreen = !suspended && !knobNow;
    next_s.panel.stateRed = suspended || knobNow;
    next_s.panel.selectionColon = knobNow || s.selMs != 16'h0000;
    next_s.panel.targetLock = locked;
    next_s.panel.dots = (s.ctrl.hold || s.ctrl.calShow) ? 4'hf : 4'h0;
    if (knobNow || s.selMs != 16'h0000 || !s.ctrl.speedEnable) begin
      next_s.panel.digits = ppg_bcd(s.target);
    end else begin
      next_s.panel.digits = ppg_bcd(s.propRpm);
    end
    // ======================================================================
    // AXI4-Lite write: address and data taken in either order.
    if (awvalid && !s.awHeld) begin
      next_s.awHeld = 1'b1;
      next_s.awAddr = awaddr;
    end
    if (wvalid && !s.wHeld) begin
      next_s.wHeld = 1'b1;
      next_s.wData = wdata;
      next_s.wStrb = wstrb;
    end
    if (s.awHeld && s.wHeld && !s.bv) begin
      doWrite = 1'b1;
      next_s.awHeld = 1'b0;
      next_s.wHeld = 1'b0;
      next_s.bv = 1'b1;
      next_s.br = 2'b00;
    end else if (s.bv && bready) begin
      next_s.bv = 1'b0;
    end
    if (doWrite) begin
      unique case (s.awAddr)
        `PPG_CTRL_OFS: cur = {29'h0, s.ctrl.calShow, s.ctrl.speedEnable, s.ctrl.hold};
        `PPG_TARGET_OFS: cur = {20'h0, s.target};
        `PPG_GEAR_OFS: cur = {16'h0, s.gear};
        `PPG_MAXRPM_OFS: cur = {20'h0, s.maxRpm};
        default: next_s.br = 2'b10;
      endcase
      // Bytes without a strobe keep their present value, so a partial write of
      // one field leaves the others alone.
      wv = s.wData;
      for (int i = 0; i < 4; i++) begin
        merged[i*8 +: 8] = s.wStrb[i] ? wv[i*8 +: 8] : cur[i*8 +: 8];
      end
      unique case (s.awAddr)
        `PPG_CTRL_OFS: begin
          next_s.ctrl.hold = merged[`PPG_CTRL_HOLD];
          next_s.ctrl.speedEnable = merged[`PPG_CTRL_SPDEN];
          next_s.ctrl.calShow = merged[`PPG_CTRL_CALSHOW];
        end
        `PPG_TARGET_OFS: begin
          next_s.target = (merged[11:0] > s.maxRpm) ? s.maxRpm : merged[11:0];
          next_s.holdFrozen = 1'b0;
        end
        `PPG_GEAR_OFS: next_s.gear = merged[15:0];
        `PPG_MAXRPM_OFS: begin
          if (merged[31:12] != 20'h0 || merged[11:0] > `PPG_MAXRPM_LIMIT) begin
            next_s.br = 2'b10;
          end else begin
            next_s.maxRpm = merged[11:0];
          end
        end
        default: begin
        end
      endcase
    end
    // A read and a write may be under way together; the read answers from the present state.
    // AXI4-Lite read: one outstanding, answer one cycle after address.
    if (arvalid && !s.rv) begin
      next_s.rv = 1'b1;
      next_s.rr = 2'b00;
      unique case (araddr)
        `PPG_CTRL_OFS: next_s.rd = {29'h0, s.ctrl.calShow, s.ctrl.speedEnable, s.ctrl.hold};
        `PPG_TARGET_OFS: next_s.rd = {20'h0, s.target};
        `PPG_GEAR_OFS: next_s.rd = {16'h0, s.gear};
        `PPG_MAXRPM_OFS: next_s.rd = {20'h0, s.maxRpm};
        `PPG_STATUS_OFS: next_s.rd = {24'h0, s.holdFrozen, s.powerUp, s.drive,
                                      s.panel.selectionColon, locked, s.panel.stateGreen,
                                      s.pulseSeen};
        `PPG_SPEED_OFS: next_s.rd = {20'h0, s.propRpm};
        default: begin
          next_s.rd = 32'h0;
          next_s.rr = 2'b10;
        end
      endcase
    end else if (s.rv && rready) begin
      next_s.rv = 1'b0;
    end
  end

  // ======================================================================
  // State register; reset drives toward fine pitch with the stored target.
  // Timers come out of reset at zero, so the colon and the resume delay start idle;
  // the motor heads for fine pitch from the first edge after release.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s <= '0;
      s.ctrl.speedEnable <= 1'b1;
      s.target <= `PPG_TARGET_RST;
      s.gear <= `PPG_GEAR_RST;
      s.maxRpm <= `PPG_MAXRPM_RST;
      s.powerUp <= 1'b1;
      s.panel.stateRed <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Ready outputs follow the held flags directly; every data output is a flip-flop.
  // Bus handshakes and registered outputs.
  assign awready = !s.awHeld;
  assign wready = !s.wHeld;
  assign bvalid = s.bv;
  assign bresp = s.br;
  assign arready = !s.rv;
  assign rvalid = s.rv;
  assign rdata = s.rd;
  assign rresp = s.rr;
  assign servo = s.servo;
  assign panel = s.panel;
endmodule
`default_nettype wire

// [ppg_governor_monitor.sv]
// Port checker for the pitch governor.
// Assumes it is bound to ppg_governor and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
// ====================
// Checker
module ppg_governor_monitor #(
  parameter int TICK_CYC = 10000
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Bus handshakes.
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic bvalid,
  input wire logic bready,
  // Knob and hub inputs.
  input wire logic knobBusy,
  input wire logic fineStop,
  input wire logic coarseStop,
  // Servo and panel.
  input wire ppg_pkg::ppg_servo_t servo,
  input wire ppg_pkg::ppg_panel_t panel
);
  // Six-cycle runs leave room for the two-stage input synchronisers.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_one_direction: assert property (!(servo.motorA && servo.motorB))
    else $error("servo driven both ways");
  a_state_colour: assert property (panel.stateGreen != panel.stateRed)
    else $error("state colour not exclusive");
  a_knob_suspends: assert property (knobBusy [*6] |-> !servo.motorA && !servo.motorB && panel.stateRed)
    else $error("drive while knob busy");
  a_knob_colon: assert property (knobBusy [*6] |-> panel.selectionColon)
    else $error("colon dark while knob busy");
  a_fine_stop: assert property (fineStop [*6] |-> !servo.motorA)
    else $error("fine drive at fine stop");
  a_coarse_stop: assert property (coarseStop [*6] |-> !servo.motorB)
    else $error("coarse drive at coarse stop");
  a_low_digit: assert property (panel.digits[3:0] == 4'h0)
    else $error("low digit not zero");
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  a_write_stands: assert property (bvalid && !bready |=> bvalid)
    else $error("write response dropped");
  c_lock: cover property (panel.targetLock);
  c_coarse: cover property (servo.motorB);
  c_colon_off: cover property ($fell(panel.selectionColon));
endmodule
bind ppg_governor ppg_governor_monitor #(.TICK_CYC(TICK_CYC)) u_mon (.clk(clk), .nrst(nrst),
  .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .bvalid(bvalid), .bready(bready),
  .knobBusy(knobBusy), .fineStop(fineStop), .coarseStop(coarseStop), .servo(servo),
  .panel(panel));
`default_nettype wire

// [ppg_plant_model.sv]
// Behavioural hub and engine on the governor's servo and injector pins.
// Assumes no inertia: injector period follows blade position at once.
`timescale 1ns/1ps
`default_nettype none
// ====================
// Hub and engine
module ppg_plant_model (
  // Clock and engine run request.
  input wire logic clk,
  input wire logic engineOn,
  // Servo drive.
  input wire ppg_pkg::ppg_servo_t servo,
  // Stops and injector line.
  output logic fineStop,
  output logic coarseStop,
  output logic injectorPulse
);
  int pos = 3;
  int stepCnt = 0;
  int pulseCnt = 0;
  // Slow steps let the governor see a full period before the blade moves again.
  always @(posedge clk) begin
    stepCnt <= ((servo.motorA || servo.motorB) && stepCnt < 1999) ? stepCnt + 1 : 0;
    if (stepCnt == 1999 && servo.motorA && pos > 0) pos <= pos - 1;
    if (stepCnt == 1999 && servo.motorB && pos < 100) pos <= pos + 1;
    pulseCnt <= (pulseCnt >= (40 + pos) * 10 - 1) ? 0 : pulseCnt + 1;
  end
  // One-cycle pulse; period in ms is 40 plus the blade position.
  assign injectorPulse = engineOn && pulseCnt == 1;
  assign fineStop = pos == 0;
  assign coarseStop = pos == 100;
endmodule
`default_nettype wire

// [prop_pitch_rpm_governor_test.sv]
// Self-checking bench for the pitch governor.
// Assumes the plant model on the servo pins and a timebase tick of 10 cycles.
`include "ppg_regs.svh"
`timescale 1ns/1ps
`default_nettype none
// ====================
// Bench top
module prop_pitch_rpm_governor_test;
  logic clk, nrst, awvalid, wvalid, bready, arvalid, rready, knobBusy, engineOn;
  logic awready, wready, bvalid, arready, rvalid, injectorPulse, fineStop, coarseStop;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [11:0] knobRpm;
  logic [1:0] bresp, rresp, r;
  ppg_pkg::ppg_servo_t servo;
  ppg_pkg::ppg_panel_t panel;
  int n_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  ppg_governor #(.TICK_CYC(10)) u_dut (.clk(clk), .nrst(nrst), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .knobBusy(knobBusy), .knobRpm(knobRpm), .injectorPulse(injectorPulse),
    .fineStop(fineStop), .coarseStop(coarseStop), .servo(servo), .panel(panel));
  ppg_plant_model u_plant (.clk(clk), .engineOn(engineOn), .servo(servo),
    .fineStop(fineStop), .coarseStop(coarseStop), .injectorPulse(injectorPulse));
  // Clock at 10 MHz.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // A hang is cut short well past the expected run length.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 95000) begin
      n_errors++;
      results();
    end
  end
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic results;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Each channel is released at the edge that takes it.
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] v);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
    // One edge passes so that a following call never re-raises it in the same step.
    @(posedge clk);
  endtask
  task automatic axiRead(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic t_power_up;
    repeat (4) @(posedge clk);
    check("drive fine", 1, servo.motorA);
    while (!fineStop) @(posedge clk);
    repeat (20) @(posedge clk);
    check("drive at stop", 0, {servo.motorA, servo.motorB});
    check("stop red", 1, panel.stateRed);
    check("idle digits", 16'h0000, panel.digits);
  endtask
  task automatic t_registers;
    logic [31:0] rst [4] = '{32'h2, 32'd2500, 32'h100, 32'd2700};
    for (int i = 0; i < 4; i++) begin
      axiRead(8'(4 * i));
      check("reset value", rst[i], d);
    end
    axiRead(8'h18);
    check("unmapped resp", 2'b10, r);
    axiWrite(`PPG_MAXRPM_OFS, 32'd2901);
    check("max refused", 2'b10, r);
    axiRead(`PPG_MAXRPM_OFS);
    check("max kept", 32'd2700, d);
    axiWrite(`PPG_MAXRPM_OFS, 32'd2900);
    check("max taken", 2'b00, r);
  endtask
  task automatic t_display;
    axiWrite(`PPG_CTRL_OFS, 32'h0);
    repeat (30) @(posedge clk);
    check("target shown", 16'h2500, panel.digits);
    axiWrite(`PPG_CTRL_OFS, 32'h3);
    repeat (30) @(posedge clk);
    check("hold dots", 4'hf, panel.dots);
    axiWrite(`PPG_CTRL_OFS, 32'h2);
    repeat (30) @(posedge clk);
    check("dots off", 4'h0, panel.dots);
    axiWrite(`PPG_CTRL_OFS, 32'h6);
    repeat (30) @(posedge clk);
    check("calibration dots", 4'hf, panel.dots);
    axiWrite(`PPG_CTRL_OFS, 32'h2);
  endtask
  task automatic t_govern;
    engineOn <= 1'b1;
    while (!servo.motorB) @(posedge clk);
    @(posedge clk);
    check("green", 1, panel.stateGreen);
    while (!panel.targetLock) @(posedge clk);
    repeat (2000) @(posedge clk);
    check("locked speed", 16'h2500, panel.digits);
    check("lock dot", 1, panel.targetLock);
  endtask
  task automatic t_knob;
    int n;
    knobRpm <= 12'd2400;
    knobBusy <= 1'b1;
    repeat (50) @(posedge clk);
    check("knob red", 1, panel.stateRed);
    check("knob colon", 1, panel.selectionColon);
    knobBusy <= 1'b0;
    n = 0;
    while (!servo.motorB) begin
      @(posedge clk);
      n++;
    end
    check("resume delay", 1, n >= 9000 && n <= 20000);
    while (panel.selectionColon) begin
      @(posedge clk);
      n++;
    end
    check("colon timeout", 1, n >= 29000 && n <= 32000);
    repeat (3000) @(posedge clk);
    check("new speed", 16'h2400, panel.digits);
  endtask
  task automatic t_hold;
    int n;
    axiWrite(`PPG_CTRL_OFS, 32'h3);
    axiWrite(`PPG_GEAR_OFS, 32'h180);
    n = 0;
    repeat (2000) begin
      @(posedge clk);
      if (servo.motorA || servo.motorB) n++;
    end
    check("frozen", 0, n);
    check("scaled speed", 16'h3600, panel.digits);
    axiWrite(`PPG_CTRL_OFS, 32'h2);
    repeat (100) @(posedge clk);
    check("coarse again", 1, servo.motorB);
  endtask
  // Main sequence.
  initial begin
    nrst <= 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, knobBusy, engineOn} <= 7'h00;
    {awaddr, araddr, wdata, knobRpm} <= 60'h0;
    wstrb <= 4'hf;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    t_power_up();
    t_registers();
    t_display();
    t_govern();
    t_knob();
    t_hold();
    results();
  end
endmodule
`default_nettype wire
